//--- dior_pkg.sv
// package: register map, field layout and timing for the digital io routing block
package dior_pkg;
  localparam int unsigned DIOR_CLK_HZ         = 100_000_000;
  localparam int unsigned DIOR_SAMPLE_MS      = 1;
  localparam int unsigned DIOR_SAMPLE_CYC     = DIOR_CLK_HZ / 1000 * DIOR_SAMPLE_MS;
  localparam int unsigned DIOR_LED_HALF_MS    = 250;
  localparam int unsigned DIOR_LED_HALF_TICKS = DIOR_LED_HALF_MS / DIOR_SAMPLE_MS;
  localparam int unsigned DIOR_NUM_OUT        = 4;

  // register byte offsets
  localparam logic [11:0] DIOR_A_IN_WORD    = 12'h000;
  localparam logic [11:0] DIOR_A_OUT_WORD   = 12'h004;
  localparam logic [11:0] DIOR_A_OUT_POL    = 12'h008;
  localparam logic [11:0] DIOR_A_OUT_MEN    = 12'h00c;
  localparam logic [11:0] DIOR_A_OUT_MVAL   = 12'h010;
  localparam logic [11:0] DIOR_A_OUT_APPL   = 12'h014;
  localparam logic [11:0] DIOR_A_OUT_RTEN   = 12'h018;
  localparam logic [11:0] DIOR_A_LED_CTRL   = 12'h01c;
  localparam logic [11:0] DIOR_A_IN_SFEN    = 12'h020;
  localparam logic [11:0] DIOR_A_IN_POL     = 12'h024;
  localparam logic [11:0] DIOR_A_IN_FEN     = 12'h028;
  localparam logic [11:0] DIOR_A_IN_FVAL    = 12'h02c;
  localparam logic [11:0] DIOR_A_IN_RTEN    = 12'h030;
  localparam logic [11:0] DIOR_A_STATUS     = 12'h034;
  localparam logic [11:0] DIOR_A_IN_RSEL    = 12'h100; // 32 words, one per input word bit
  localparam logic [11:0] DIOR_A_OUT_RSEL   = 12'h200; // one word per output pin

  // input source codes
  localparam logic [6:0] DIOR_SRC_ZERO     = 7'h00;
  localparam logic [6:0] DIOR_SRC_PHYS_LO  = 7'h01;
  localparam logic [6:0] DIOR_SRC_PHYS_HI  = 7'h10;
  localparam logic [6:0] DIOR_SRC_HALL_U   = 7'h41;
  localparam logic [6:0] DIOR_SRC_ENC_IDX  = 7'h46;
  localparam logic [6:0] DIOR_SRC_NET      = 7'h48;
  localparam int unsigned DIOR_SRC_INV_BIT = 7;

  // output source codes (high byte of an output route entry)
  // one external source code per ext_src bit, ten in all
  localparam logic [7:0] DIOR_OSRC_ONE     = 8'h00;
  localparam logic [7:0] DIOR_OSRC_ZERO    = 8'h01;
  localparam logic [7:0] DIOR_OSRC_EXT_LO  = 8'h02;
  localparam logic [7:0] DIOR_OSRC_EXT_HI  = 8'h0b;
  localparam int unsigned DIOR_CTRL_INV_BIT = 7;

  // field positions
  localparam int unsigned DIOR_INTERLOCK_BIT = 3;
  localparam int unsigned DIOR_BRAKE_BIT     = 0;
  localparam int unsigned DIOR_OUT_BASE      = 16;
  localparam int unsigned DIOR_IN_BASE       = 16;
  localparam int unsigned DIOR_LED_GREEN_BIT = 0;
  localparam int unsigned DIOR_LED_RED_BIT   = 1;

  // reset values
  localparam logic [31:0] DIOR_RST_WORD  = 32'h0000_0000;
  localparam logic [7:0]  DIOR_RST_IRSEL = 8'h00;
  localparam logic [15:0] DIOR_RST_ORSEL = 16'hffff;
  localparam logic [1:0]  DIOR_RST_LED   = 2'h3;
endpackage

//--- dior_top.sv
// digital input/output conditioning and routing with an apb register slave
`timescale 1ns/1ps
// How it works
// - one route entry per input word bit
// - source codes select zero, inputs, hall, encoder, net
// - code plus 80 hex inverts the source
// - interlock bit low forces error state
// - interlock acts with special enable bit 3, or always in input routing mode
// - output n follows output word bit 16+n
// - output word bit 0 drives brake
// - polarity one drives inverted pin level
// - manual enable substitutes manual value, brake too
// - applied pin pattern is readable
// - led control bits enable green and red
// - routed output is source gated by control bit
// - route entry: source high byte, gate low
// - route enable switches output routing mode
// - routing ignores polarity and manual settings
// - input routing ignores special, polarity, force
// - inputs sampled once per millisecond
module dior_top import dior_pkg::*; #(
  parameter int unsigned NUM_OUT    = DIOR_NUM_OUT,
  parameter int unsigned SAMPLE_CYC = DIOR_SAMPLE_CYC
) (
  input  wire logic               mclk,
  input  wire logic               rst,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [11:0]        paddr,
  input  wire logic [31:0]        pwdata,
  input  wire logic [3:0]         pstrb,
  output logic      [31:0]        prdata,
  output logic                    pready,
  output logic                    pslverr,
  input  wire logic [15:0]        phys_in,
  input  wire logic [2:0]         hall_in,
  input  wire logic [2:0]         enc_in,
  input  wire logic               net_active,
  input  wire logic [9:0]         ext_src,
  input  wire logic               drive_error,
  output logic      [NUM_OUT-1:0] out_pin_o,
  output logic      [NUM_OUT-1:0] out_pin_oe,
  output logic                    brake_o,
  output logic                    motion_enable,
  output logic                    interlock_fault,
  output logic                    led_green,
  output logic                    led_red
);

  logic [31:0] in_word_r;
  logic [31:0] out_word_r;
  logic [31:0] out_pol_r;
  logic [31:0] out_men_r;
  logic [31:0] out_mval_r;
  logic [31:0] out_appl_r;
  logic        out_rten_r;
  logic [1:0]  led_ctrl_r;
  logic [31:0] in_sfen_r;
  logic [31:0] in_pol_r;
  logic [31:0] in_fen_r;
  logic [31:0] in_fval_r;
  logic        in_rten_r;
  logic [7:0]  in_rsel_r [32];
  logic [15:0] out_rsel_r [NUM_OUT];
  logic [15:0] phys_smp_r;
  logic [2:0]  hall_smp_r;
  logic [2:0]  enc_smp_r;
  logic        net_smp_r;
  logic [31:0] tick_cnt_r;
  logic        tick;
  logic [31:0] in_word_nxt;
  logic [31:0] out_appl_nxt;
  logic [31:0] rdata_nxt;
  logic        addr_ok;
  logic        wr_en;
  logic [31:0] wmask;
  logic [8:0]  led_cnt_r;
  logic        led_phase_r;

  // apb: zero wait states, so pready stays high; unmapped addresses raise pslverr
  assign pready = 1'b1;
  assign wr_en  = psel && penable && pwrite && addr_ok;
  assign wmask  = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};

  always_ff @(posedge mclk) begin
    if (rst || tick) begin
      tick_cnt_r <= 32'h0000_0000;
    end else begin
      tick_cnt_r <= tick_cnt_r + 32'h0000_0001;
    end
  end
  assign tick = (tick_cnt_r == 32'(SAMPLE_CYC - 1));

  // sample raw lines only on the tick
  always_ff @(posedge mclk) begin
    if (rst) begin
      phys_smp_r <= 16'h0000;
      hall_smp_r <= 3'h0;
      enc_smp_r  <= 3'h0;
      net_smp_r  <= 1'b0;
    end else if (tick) begin
      phys_smp_r <= phys_in;
      hall_smp_r <= hall_in;
      enc_smp_r  <= enc_in;
      net_smp_r  <= net_active;
    end
  end

  function automatic logic route_bit(input logic [7:0] code, input logic [15:0] ph,
                                     input logic [2:0] ha, input logic [2:0] en,
                                     input logic nt);
    logic [6:0] c;
    logic       v;
    c = code[6:0];
    v = 1'b0;
    if (c >= DIOR_SRC_PHYS_LO && c <= DIOR_SRC_PHYS_HI) begin
      v = ph[4'(c - DIOR_SRC_PHYS_LO)];
    end else if (c >= DIOR_SRC_HALL_U && c <= DIOR_SRC_HALL_U + 7'h02) begin
      v = ha[2'(c - DIOR_SRC_HALL_U)];
    end else if (c > DIOR_SRC_HALL_U + 7'h02 && c <= DIOR_SRC_ENC_IDX) begin
      v = en[2'(c - DIOR_SRC_HALL_U - 7'h03)];
    end else if (c == DIOR_SRC_NET) begin
      v = nt;
    end else if (c == DIOR_SRC_ZERO) begin
      v = 1'b0;
    end else begin
      // unlisted codes give zero, inverted or not
      return 1'b0;
    end
    // high bit of the code inverts
    return v ^ code[DIOR_SRC_INV_BIT];
  endfunction

  // input word: routed mode or classic mapping
  always_comb begin
    logic v;
    in_word_nxt = 32'h0000_0000;
    v           = 1'b0;
    for (int b = 0; b < 32; b++) begin
      if (in_rten_r) begin
        // entry b drives bit b; classic settings bypassed
        in_word_nxt[b] = route_bit(in_rsel_r[b], phys_smp_r, hall_smp_r, enc_smp_r, net_smp_r);
      end
    end
    if (!in_rten_r) begin
      for (int i = 0; i < 16; i++) begin
        v = in_fen_r[i] ? in_fval_r[i] : (phys_smp_r[i] ^ in_pol_r[i]);
        in_word_nxt[DIOR_IN_BASE + i] = v;
        in_word_nxt[i] = v & in_sfen_r[i];
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      in_word_r <= DIOR_RST_WORD;
    end else begin
      in_word_r <= in_word_nxt;
    end
  end

  // interlock; in routing mode the special enable is ignored, so always armed
  always_comb begin
    interlock_fault = (in_rten_r || in_sfen_r[DIOR_INTERLOCK_BIT])
                      && !in_word_r[DIOR_INTERLOCK_BIT];
    motion_enable   = !interlock_fault;
  end

  // output computation
  always_comb begin
    logic [7:0] src;
    logic [7:0] gsel;
    logic       g;
    logic       s;
    logic       v;
    out_appl_nxt = 32'h0000_0000;
    src          = 8'h00;
    gsel         = 8'h00;
    g            = 1'b0;
    s            = 1'b0;
    v            = 1'b0;
    if (out_rten_r) begin
      for (int n = 0; n < NUM_OUT; n++) begin
        src  = out_rsel_r[n][15:8];
        gsel = out_rsel_r[n][7:0];
        g    = out_word_r[gsel[4:0]] ^ gsel[DIOR_CTRL_INV_BIT];
        if (src == DIOR_OSRC_ONE) begin
          s = 1'b1;
        end else if (src >= DIOR_OSRC_EXT_LO && src <= DIOR_OSRC_EXT_HI) begin
          s = ext_src[4'(src - DIOR_OSRC_EXT_LO)];
        end else begin
          s = 1'b0;
        end
        // gated source, polarity and manual bypassed
        out_appl_nxt[DIOR_OUT_BASE + n] = s & g;
      end
      out_appl_nxt[DIOR_BRAKE_BIT] = out_word_r[DIOR_BRAKE_BIT];
    end else begin
      for (int b = 0; b < 32; b++) begin
        v = out_men_r[b] ? out_mval_r[b] : out_word_r[b];
        out_appl_nxt[b] = v ^ out_pol_r[b];
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      out_appl_r <= DIOR_RST_WORD;
    end else begin
      out_appl_r <= out_appl_nxt;
    end
  end

  // open drain: a low level is driven, a high level released to the pull-up
  genvar gn;
  generate
    for (gn = 0; gn < NUM_OUT; gn++) begin : g_pin
      // output n from word bit 16+n
      assign out_pin_o[gn]  = 1'b0;
      assign out_pin_oe[gn] = !out_appl_r[DIOR_OUT_BASE + gn];
    end
  endgenerate

  assign brake_o = out_appl_r[DIOR_BRAKE_BIT];

  // led flasher runs on the millisecond tick
  always_ff @(posedge mclk) begin
    if (rst) begin
      led_cnt_r   <= 9'h000;
      led_phase_r <= 1'b0;
    end else if (tick) begin
      if (led_cnt_r == 9'(DIOR_LED_HALF_TICKS - 1)) begin
        led_cnt_r   <= 9'h000;
        led_phase_r <= !led_phase_r;
      end else begin
        led_cnt_r <= led_cnt_r + 9'h001;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      led_green <= 1'b0;
      led_red   <= 1'b0;
    end else begin
      led_green <= led_ctrl_r[DIOR_LED_GREEN_BIT] && !drive_error && !interlock_fault
                   && led_phase_r;
      led_red   <= led_ctrl_r[DIOR_LED_RED_BIT] && (drive_error || interlock_fault)
                   && led_phase_r;
    end
  end

  // address decode
  always_comb begin
    addr_ok = 1'b1;
    if (paddr[11:8] == DIOR_A_IN_RSEL[11:8]) begin
      addr_ok = (paddr[1:0] == 2'h0) && (paddr[7] == 1'b0);
    end else if (paddr[11:8] == DIOR_A_OUT_RSEL[11:8]) begin
      addr_ok = (paddr[1:0] == 2'h0) && (32'(paddr[7:2]) < NUM_OUT);
    end else begin
      case (paddr)
        DIOR_A_IN_WORD, DIOR_A_OUT_WORD, DIOR_A_OUT_POL, DIOR_A_OUT_MEN,
        DIOR_A_OUT_MVAL, DIOR_A_OUT_APPL, DIOR_A_OUT_RTEN, DIOR_A_LED_CTRL,
        DIOR_A_IN_SFEN, DIOR_A_IN_POL, DIOR_A_IN_FEN, DIOR_A_IN_FVAL,
        DIOR_A_IN_RTEN, DIOR_A_STATUS: addr_ok = 1'b1;
        default: addr_ok = 1'b0;
      endcase
    end
  end

  always_comb begin
    pslverr = psel && penable && !addr_ok;
  end

  // register writes
  always_ff @(posedge mclk) begin
    if (rst) begin
      out_word_r <= DIOR_RST_WORD;
      out_pol_r  <= DIOR_RST_WORD;
      out_men_r  <= DIOR_RST_WORD;
      out_mval_r <= DIOR_RST_WORD;
      out_rten_r <= 1'b0;
      led_ctrl_r <= DIOR_RST_LED;
      in_sfen_r  <= DIOR_RST_WORD;
      in_pol_r   <= DIOR_RST_WORD;
      in_fen_r   <= DIOR_RST_WORD;
      in_fval_r  <= DIOR_RST_WORD;
      in_rten_r  <= 1'b0;
    end else if (wr_en) begin
      case (paddr)
        DIOR_A_OUT_WORD: out_word_r <= (out_word_r & ~wmask) | (pwdata & wmask);
        DIOR_A_OUT_POL:  out_pol_r  <= (out_pol_r & ~wmask) | (pwdata & wmask);
        DIOR_A_OUT_MEN:  out_men_r  <= (out_men_r & ~wmask) | (pwdata & wmask);
        DIOR_A_OUT_MVAL: out_mval_r <= (out_mval_r & ~wmask) | (pwdata & wmask);
        DIOR_A_OUT_RTEN: if (pstrb[0]) out_rten_r <= pwdata[0];
        DIOR_A_LED_CTRL: if (pstrb[0]) led_ctrl_r <= pwdata[1:0];
        DIOR_A_IN_SFEN:  in_sfen_r  <= (in_sfen_r & ~wmask) | (pwdata & wmask);
        DIOR_A_IN_POL:   in_pol_r   <= (in_pol_r & ~wmask) | (pwdata & wmask);
        DIOR_A_IN_FEN:   in_fen_r   <= (in_fen_r & ~wmask) | (pwdata & wmask);
        DIOR_A_IN_FVAL:  in_fval_r  <= (in_fval_r & ~wmask) | (pwdata & wmask);
        DIOR_A_IN_RTEN:  if (pstrb[0]) in_rten_r <= pwdata[0];
        default: ;
      endcase
    end
  end

  // route tables
  always_ff @(posedge mclk) begin
    if (rst) begin
      for (int i = 0; i < 32; i++) begin
        in_rsel_r[i] <= DIOR_RST_IRSEL;
      end
      for (int i = 0; i < NUM_OUT; i++) begin
        out_rsel_r[i] <= DIOR_RST_ORSEL;
      end
    end else if (wr_en && paddr[11:8] == DIOR_A_IN_RSEL[11:8]) begin
      if (pstrb[0]) in_rsel_r[paddr[6:2]] <= pwdata[7:0];
    end else if (wr_en && paddr[11:8] == DIOR_A_OUT_RSEL[11:8]) begin
      for (int i = 0; i < NUM_OUT; i++) begin
        if (32'(paddr[7:2]) == i) begin
          if (pstrb[0]) out_rsel_r[i][7:0]  <= pwdata[7:0];
          if (pstrb[1]) out_rsel_r[i][15:8] <= pwdata[15:8];
        end
      end
    end
  end

  // read mux
  always_comb begin
    rdata_nxt = 32'h0000_0000;
    if (paddr[11:8] == DIOR_A_IN_RSEL[11:8]) begin
      rdata_nxt = {24'h000000, in_rsel_r[paddr[6:2]]};
    end else if (paddr[11:8] == DIOR_A_OUT_RSEL[11:8]) begin
      for (int i = 0; i < NUM_OUT; i++) begin
        if (32'(paddr[7:2]) == i) rdata_nxt = {16'h0000, out_rsel_r[i]};
      end
    end else begin
      case (paddr)
        DIOR_A_IN_WORD:  rdata_nxt = in_word_r;
        DIOR_A_OUT_WORD: rdata_nxt = out_word_r;
        DIOR_A_OUT_POL:  rdata_nxt = out_pol_r;
        DIOR_A_OUT_MEN:  rdata_nxt = out_men_r;
        DIOR_A_OUT_MVAL: rdata_nxt = out_mval_r;
        DIOR_A_OUT_APPL: rdata_nxt = out_appl_r;
        DIOR_A_OUT_RTEN: rdata_nxt = {31'h0, out_rten_r};
        DIOR_A_LED_CTRL: rdata_nxt = {30'h0, led_ctrl_r};
        DIOR_A_IN_SFEN:  rdata_nxt = in_sfen_r;
        DIOR_A_IN_POL:   rdata_nxt = in_pol_r;
        DIOR_A_IN_FEN:   rdata_nxt = in_fen_r;
        DIOR_A_IN_FVAL:  rdata_nxt = in_fval_r;
        DIOR_A_IN_RTEN:  rdata_nxt = {31'h0, in_rten_r};
        DIOR_A_STATUS:   rdata_nxt = {30'h0, interlock_fault, motion_enable};
        default:         rdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  // read data registered in the setup phase so the access phase can answer at once
  always_ff @(posedge mclk) begin
    if (rst) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= rdata_nxt;
    end
  end

endmodule

//--- dior_props.sv
// checker: port-level properties of the digital io routing block
`timescale 1ns/1ps
module dior_props import dior_pkg::*; #(
  parameter int unsigned NUM_OUT    = DIOR_NUM_OUT,
  parameter int unsigned SAMPLE_CYC = DIOR_SAMPLE_CYC
) (
  input wire logic               mclk,
  input wire logic               rst,
  input wire logic               psel,
  input wire logic               penable,
  input wire logic               pwrite,
  input wire logic [11:0]        paddr,
  input wire logic               pready,
  input wire logic               pslverr,
  input wire logic [9:0]         ext_src,
  input wire logic [NUM_OUT-1:0] out_pin_o,
  input wire logic [NUM_OUT-1:0] out_pin_oe,
  input wire logic               brake_o,
  input wire logic               motion_enable,
  input wire logic               interlock_fault,
  input wire logic               led_green,
  input wire logic               led_red
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);
  logic       wr;
  logic [1:0] settle_r;
  assign wr = psel & penable & pwrite;
  // history checks wait for three clean edges so no pre-reset value is compared
  always_ff @(posedge mclk) begin
    if (rst) begin
      settle_r <= 2'h0;
    end else if (settle_r != 2'h3) begin
      settle_r <= settle_r + 2'h1;
    end
  end
  AST_MOTION: assert property (motion_enable == !interlock_fault)
    else $error("motion enable disagrees with interlock fault");
  AST_OPEN_DRAIN: assert property (out_pin_o == '0)
    else $error("open drain pin driven high");
  AST_LED_EXCL: assert property (!(led_green && led_red))
    else $error("both leds lit");
  // register plus applied stage: a write shows two edges later
  AST_BRAKE_CAUSE: assert property (settle_r == 2'h3 && $changed(brake_o)
    |-> $past(wr, 2))
    else $error("brake moved without a write");
  AST_PIN_CAUSE: assert property (settle_r == 2'h3 && $changed(out_pin_oe)
    |-> $past(wr, 2) || $past(ext_src) != $past(ext_src, 2)
    || $past(ext_src, 2) != $past(ext_src, 3))
    else $error("pins moved without a cause");
  AST_ERR_PHASE: assert property (pslverr |-> psel && penable)
    else $error("slave error outside access");
  AST_UNMAPPED: assert property (psel && penable && paddr == 12'hffc |-> pslverr)
    else $error("unmapped access not refused");
  AST_MAPPED: assert property (psel && penable && paddr == DIOR_A_OUT_WORD |-> !pslverr)
    else $error("mapped access refused");
  AST_NO_WAIT: assert property (psel && !penable ##1 penable |-> pready)
    else $error("access phase stalled");
  cover property ($rose(interlock_fault));
  cover property (pslverr);
  cover property ($rose(brake_o));
  cover property ($rose(led_red));
endmodule
bind dior_top dior_props #(.NUM_OUT(NUM_OUT), .SAMPLE_CYC(SAMPLE_CYC)) u_props (
  .mclk(mclk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pready(pready), .pslverr(pslverr), .ext_src(ext_src),
  .out_pin_o(out_pin_o), .out_pin_oe(out_pin_oe), .brake_o(brake_o),
  .motion_enable(motion_enable), .interlock_fault(interlock_fault),
  .led_green(led_green), .led_red(led_red));

//--- dior_field.sv
// partner model: switches, sensors and pulled-up loads on the pins
`timescale 1ns/1ps
module dior_field #(
  parameter int unsigned NUM_OUT = 4
) (
  output logic      [15:0]        phys_in,
  output logic      [2:0]         hall_in,
  output logic      [2:0]         enc_in,
  output logic                    net_active,
  output logic      [9:0]         ext_src,
  input  wire logic [NUM_OUT-1:0] out_pin_o,
  input  wire logic [NUM_OUT-1:0] out_pin_oe,
  output logic      [NUM_OUT-1:0] pin_lvl
);
  // a released pin floats up through the external pull-up
  assign pin_lvl = ~out_pin_oe | out_pin_o;
  // called just after a clock edge so levels never race the sampler
  task automatic drive(input logic [15:0] p, input logic [2:0] h,
                       input logic [2:0] e, input logic n, input logic [9:0] x);
    phys_in    <= p;
    hall_in    <= h;
    enc_in     <= e;
    net_active <= n;
    ext_src    <= x;
  endtask
endmodule

//--- tb_digital_io_routing.sv
// testbench: registers, routing and pin scenarios for the io routing block
`timescale 1ns/1ps
module tb_digital_io_routing;
  import dior_pkg::*;
  localparam int SC = 10;
  logic        mclk, rst, psel, penable, pwrite, pready, pslverr, e;
  logic        net_active, drive_error, brake_o, motion_enable;
  logic        interlock_fault, led_green, led_red;
  logic [2:0]  hall_in, enc_in;
  logic [3:0]  pstrb, out_pin_o, out_pin_oe, pin_lvl;
  logic [9:0]  ext_src;
  logic [11:0] paddr;
  logic [15:0] phys_in;
  logic [31:0] pwdata, prdata;
  int          bad_count, check_count;
  dior_top #(.NUM_OUT(4), .SAMPLE_CYC(SC)) uut (
    .mclk(mclk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .phys_in(phys_in), .hall_in(hall_in), .enc_in(enc_in),
    .net_active(net_active), .ext_src(ext_src), .drive_error(drive_error),
    .out_pin_o(out_pin_o), .out_pin_oe(out_pin_oe), .brake_o(brake_o),
    .motion_enable(motion_enable), .interlock_fault(interlock_fault),
    .led_green(led_green), .led_red(led_red));
  dior_field #(.NUM_OUT(4)) fld (
    .phys_in(phys_in), .hall_in(hall_in), .enc_in(enc_in), .net_active(net_active),
    .ext_src(ext_src), .out_pin_o(out_pin_o), .out_pin_oe(out_pin_oe), .pin_lvl(pin_lvl));
  initial mclk = 1'b0;
  always #5 mclk = ~mclk;
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int n;
    @(posedge mclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge mclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) bad_count++;
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    apb(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] q);
    apb(1'b0, a, 32'h0, q);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t %s: got %h expected %h", $time, m, got, exp);
    end
  endtask
  // skip a tick first so a stale flash phase is not counted
  task automatic scan(output logic [1:0] s);
    repeat (SC + 2) @(posedge mclk);
    s = 2'b00;
    repeat (5200) begin
      @(posedge mclk);
      s = s | {led_red, led_green};
    end
  endtask
  function automatic logic [7:0] code_of(int i);
    if (i >= 48) return 8'h20 + 8'(i);
    if (i >= 24) return code_of(i - 24) | 8'h80;
    if (i < 17) return 8'(i);
    if (i < 23) return 8'(i + 48);
    return 8'h48;
  endfunction
  function automatic logic isrc(input logic [7:0] c, input logic [15:0] p,
                                input logic [2:0] h, input logic [2:0] en, input logic n);
    logic [6:0] b;
    logic       v;
    b = c[6:0];
    if (b == 7'h00) v = 1'b0;
    else if (b <= 7'h10) v = p[b - 7'h01];
    else if (b >= 7'h41 && b <= 7'h43) v = h[b - 7'h41];
    else if (b >= 7'h44 && b <= 7'h46) v = en[b - 7'h44];
    else if (b == 7'h48) v = n;
    else return 1'b0;
    return v ^ c[7];
  endfunction
  function automatic logic orte(input logic [15:0] r, input logic [31:0] w,
                                input logic [9:0] x);
    logic s;
    if (r[15:8] == 8'h00) s = 1'b1;
    else if (r[15:8] >= DIOR_OSRC_EXT_LO && r[15:8] <= DIOR_OSRC_EXT_HI)
      s = x[r[15:8] - DIOR_OSRC_EXT_LO];
    else s = 1'b0;
    return s & (w[r[4:0]] ^ r[7]);
  endfunction
  initial begin
    logic [31:0] q, w, pl, me, mv, ex, fe, fv;
    logic [15:0] ph, rs [4];
    logic [9:0]  x;
    logic [2:0]  hl, en;
    logic        nt;
    logic [1:0]  s;
    {psel, penable, pwrite, paddr, pwdata, drive_error} = '0;
    {ph, hl, en, nt, x} = '0;
    pstrb = 4'hf;
    rst = 1'b1;
    bad_count = 0;
    check_count = 0;
    fld.drive(ph, hl, en, nt, x);
    void'($urandom(32'hf065));
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    rd(DIOR_A_LED_CTRL, q);
    chk(q, 32'h3, "led control reset");
    rd(DIOR_A_OUT_RSEL, q);
    chk(q, 32'hffff, "output route reset");
    chk(32'(out_pin_oe), 32'hf, "pins after reset");
    rd(12'hffc, q);
    chk(q, 32'h0, "unmapped read data");
    chk(32'(e), 32'h1, "unmapped read refused");
    for (int k = 0; k < 8; k++) begin
      w = $urandom;
      pl = $urandom;
      me = (k == 0) ? 32'h0 : $urandom;
      mv = $urandom;
      wr(DIOR_A_OUT_WORD, w);
      wr(DIOR_A_OUT_POL, pl);
      wr(DIOR_A_OUT_MEN, me);
      wr(DIOR_A_OUT_MVAL, mv);
      ex = ((me & mv) | (~me & w)) ^ pl;
      wr(DIOR_A_OUT_APPL, ~ex);
      rd(DIOR_A_OUT_APPL, q);
      chk(q, ex, "applied pattern");
      chk(32'(brake_o), 32'(ex[0]), "brake pin");
      chk(32'(pin_lvl), 32'(ex[19:16]), "output pins");
    end
    // polarity and manual settings stay loaded so routing must ignore them
    wr(DIOR_A_OUT_RTEN, 32'h1);
    for (int k = 0; k < 8; k++) begin
      w = $urandom;
      x = 10'($urandom);
      for (int n = 0; n < 4; n++) begin
        rs[n] = {8'($urandom % 20), 8'($urandom)};
        wr(DIOR_A_OUT_RSEL + 12'(4 * n), 32'(rs[n]));
      end
      fld.drive(ph, hl, en, nt, x);
      wr(DIOR_A_OUT_WORD, w);
      repeat (3) @(posedge mclk);
      for (int n = 0; n < 4; n++)
        chk(32'(pin_lvl[n]), 32'(orte(rs[n], w, x)), "routed pin");
      chk(32'(brake_o), 32'(w[0]), "brake while routed");
    end
    wr(DIOR_A_OUT_RTEN, 32'h0);
    repeat (2) @(posedge mclk);
    ex = ((me & mv) | (~me & w)) ^ pl;
    chk(32'(pin_lvl), 32'(ex[19:16]), "pins back to mapping");
    wr(DIOR_A_IN_POL, $urandom);
    wr(DIOR_A_IN_FEN, 32'hffffffff);
    wr(DIOR_A_IN_RTEN, 32'h1);
    for (int b = 0; b < 2; b++) begin
      for (int i = 0; i < 32; i++)
        wr(DIOR_A_IN_RSEL + 12'(4 * i), 32'(code_of(b * 32 + i)));
      for (int r = 0; r < 3; r++) begin
        {ph, hl, en, nt} = 23'($urandom);
        fld.drive(ph, hl, en, nt, x);
        repeat (2 * SC + 3) @(posedge mclk);
        rd(DIOR_A_IN_WORD, q);
        for (int i = 0; i < 32; i++)
          ex[i] = isrc(code_of(b * 32 + i), ph, hl, en, nt);
        chk(q, ex, "routed input word");
        chk(32'(interlock_fault), 32'(!ex[3]), "routed interlock");
      end
    end
    wr(DIOR_A_IN_RTEN, 32'h0);
    for (int k = 0; k < 6; k++) begin
      ph = 16'($urandom);
      pl = $urandom;
      fe = $urandom;
      fv = $urandom;
      fld.drive(ph, hl, en, nt, x);
      wr(DIOR_A_IN_POL, pl);
      wr(DIOR_A_IN_FEN, fe);
      wr(DIOR_A_IN_FVAL, fv);
      wr(DIOR_A_IN_SFEN, k[0] ? 32'h8 : 32'h0);
      repeat (2 * SC + 3) @(posedge mclk);
      ex = {16'h0, (fe[15:0] & fv[15:0]) | (~fe[15:0] & (ph ^ pl[15:0]))};
      rd(DIOR_A_IN_WORD, q);
      chk({16'h0, q[31:16]}, ex, "input levels");
      chk({16'h0, q[15:0]}, ex & (k[0] ? 32'h8 : 32'h0), "special bits");
      chk(32'(interlock_fault), 32'(k[0] & !ex[3]), "interlock gate");
      chk(32'(motion_enable), 32'(!(k[0] & !ex[3])), "motion enable");
    end
    wr(DIOR_A_IN_SFEN, 32'h0);
    wr(DIOR_A_LED_CTRL, 32'h0);
    scan(s);
    chk(32'(s), 32'h0, "leds disabled");
    wr(DIOR_A_LED_CTRL, 32'h1);
    scan(s);
    chk(32'(s), 32'h1, "green flashes");
    drive_error <= 1'b1;
    wr(DIOR_A_LED_CTRL, 32'h2);
    scan(s);
    chk(32'(s), 32'h2, "red flashes on error");
    summarize();
  end
  initial begin
    #400000;
    bad_count++;
    summarize();
  end
  task automatic summarize;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
endmodule
